// File: rtl/audio_ctrl_map.vh
// Constants for the three-wire control bus slave: codes, field positions, reset values
`ifndef AUDIO_CTRL_MAP_VH
`define AUDIO_CTRL_MAP_VH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define CMD_BITS          5'h10
`define ADDR_BITS         5'h08
`define ADDR_HI_MSB       7
`define ADDR_HI_LSB       3
`define DEV_ADDR_HI       5'h08
`define FUNC_MSB          2
`define FUNC_LSB          0

// ----------------------------------------------------------------------------
// Function codes (low three address bits)
// ----------------------------------------------------------------------------
`define FN_INPUT_SEL      3'h0
`define FN_LOUDNESS       3'h1
`define FN_BASS           3'h2
`define FN_TREBLE         3'h3
`define FN_VOL_LEFT       3'h4
`define FN_VOL_RIGHT      3'h5
`define FN_MODE           3'h6
`define FN_READ_STATUS    3'h7

// ----------------------------------------------------------------------------
// Value field positions
// ----------------------------------------------------------------------------
`define SEL_MSB           1
`define TONE_MSB          3
`define VOL_MSB           5
`define MODE_MSB          2
`define MODE_VALID_BIT    2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_INPUT_SEL     2'h3
`define RST_LOUDNESS      1'h0
`define RST_TONE          4'h6
`define RST_VOLUME        6'h3f
`define RST_MODE          3'h5

// ----------------------------------------------------------------------------
// Read-back byte filler (released bits read high through the pull-up)
// ----------------------------------------------------------------------------
`define RD_FILL           6'h3f

`endif

// File: rtl/pin_sync3.v
// Three-stage pin synchroniser with a two-stage agreement filter
`timescale 1ns/1ps

module pin_sync3 #(
	parameter WIDTH = 1
) (
	input  wire             sys_clk_in, // System clock
	input  wire             sys_rst_in, // Synchronous reset, active high
	input  wire [WIDTH-1:0] async_in,   // Raw pin levels
	input  wire [WIDTH-1:0] rst_val_in, // Filtered level taken at reset
	output reg  [WIDTH-1:0] level_out   // Filtered, synchronised levels
);

	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;
	integer         i;

	// ------------------------------------------------------------------------
	// Stage one feeds only stage two; a bit counts once stages two and three agree
	// ------------------------------------------------------------------------
	always @(posedge sys_clk_in) begin
		s1_q <= async_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
		if (sys_rst_in) begin
			level_out <= rst_val_in;
		end else begin
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (s2_q[i] == s3_q[i]) begin
					level_out[i] <= s3_q[i];
				end
			end
		end
	end

endmodule // pin_sync3

// File: rtl/audio_control_serial_slave.v
// Serial command slave for a stereo audio processor's three-wire control bus
`timescale 1ns/1ps
`include "audio_ctrl_map.vh"

module audio_control_serial_slave (
	input  wire       sys_clk_in,                // System clock, 25 MHz
	input  wire       sys_rst_in,                // Synchronous reset, active high
	input  wire       bus_clk_in,                // Control bus clock from controller
	input  wire       device_select_strobe_n_in, // Select strobe, frame while low
	input  wire       bus_data_in,               // Level on the shared data line
	output wire       bus_data_out,              // Drive value, always low
	output reg        bus_data_oe_n_out,         // Low while pulling data line low
	input  wire       status1_n_in,              // Status input one, active low
	input  wire       status2_n_in,              // Status input two, active low
	output reg  [1:0] input_sel_out,             // 0..2 stereo input, 3 mute
	output reg        loudness_out,              // Loudness compensation on
	output reg  [3:0] bass_out,                  // Bass step code
	output reg  [3:0] treble_out,                // Treble step code
	output reg  [5:0] volume_left_out,           // Left volume code
	output reg  [5:0] volume_right_out,          // Right volume code
	output reg  [2:0] mode_out,                  // Channel matrix code
	output reg        cmd_done_out               // One-cycle pulse per executed command
);

	// ------------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------------
	wire [4:0] pins_f;
	wire       clk_f;
	wire       strobe_n_f;
	wire       data_f;
	wire       st1_n_f;
	wire       st2_n_f;

	pin_sync3 #(
		.WIDTH (5)
	) u_sync (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({bus_clk_in, device_select_strobe_n_in, bus_data_in,
		              status1_n_in, status2_n_in}),
		.rst_val_in (5'h1f),
		.level_out  (pins_f)
	);

	assign clk_f      = pins_f[4];
	assign strobe_n_f = pins_f[3];
	assign data_f     = pins_f[2];
	assign st1_n_f    = pins_f[1];
	assign st2_n_f    = pins_f[0];

	// The device only ever pulls low; the high level comes from the pull-up
	assign bus_data_out = 1'b0;

	// ------------------------------------------------------------------------
	// Bus clock edge detection
	// ------------------------------------------------------------------------
	reg  clk_prev_q;
	wire clk_rise;
	wire clk_fall;

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			clk_prev_q <= 1'b1;
		end else begin
			clk_prev_q <= clk_f;
		end
	end

	assign clk_rise = clk_f & ~clk_prev_q;
	assign clk_fall = ~clk_f & clk_prev_q;

	// ------------------------------------------------------------------------
	// Shift register and bit counter
	// ------------------------------------------------------------------------
	reg  [15:0] shift_q;
	reg  [15:0] shift_d;
	reg  [4:0]  count_q;
	reg  [4:0]  count_d;
	reg         read_q;
	reg         read_d;
	reg  [7:0]  rd_byte_q;
	reg  [7:0]  rd_byte_d;
	reg         exec_d;
	wire        frame_on;
	wire        addr_ok;

	assign frame_on = ~strobe_n_f;
	// Address is checked on the byte as it stands after the eighth bit
	assign addr_ok = (shift_d[`ADDR_HI_MSB:`ADDR_HI_LSB] == `DEV_ADDR_HI);

	always @* begin
		shift_d   = shift_q;
		count_d   = count_q;
		read_d    = read_q;
		rd_byte_d = rd_byte_q;
		exec_d    = 1'b0;
		if (!frame_on) begin
			// Strobe high ends or aborts a frame; a short frame does nothing
			count_d = 5'h00;
			read_d  = 1'b0;
		end else if (clk_rise && count_q != `CMD_BITS) begin
			shift_d = {shift_q[14:0], data_f};
			count_d = count_q + 5'h01;
			if (count_q == `ADDR_BITS - 5'h01) begin
				if (addr_ok && shift_d[`FUNC_MSB:`FUNC_LSB] == `FN_READ_STATUS) begin
					read_d    = 1'b1;
					rd_byte_d = {`RD_FILL, st2_n_f, st1_n_f};
				end
			end
			if (count_q == `CMD_BITS - 5'h01) begin
				exec_d = 1'b1;
				read_d = 1'b0;
			end
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			shift_q   <= 16'h0000;
			count_q   <= 5'h00;
			read_q    <= 1'b0;
			rd_byte_q <= 8'hff;
		end else begin
			shift_q   <= shift_d;
			count_q   <= count_d;
			read_q    <= read_d;
			rd_byte_q <= rd_byte_d;
		end
	end

	// ------------------------------------------------------------------------
	// Read-back driver
	// ------------------------------------------------------------------------
	// New bit is set up on the falling edge so it is steady at the next rise
	wire [2:0] rd_idx;

	assign rd_idx = 3'h7 - count_q[2:0];

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			bus_data_oe_n_out <= 1'b1;
		end else if (!frame_on || !read_d) begin
			bus_data_oe_n_out <= 1'b1;
		end else if (clk_fall) begin
			bus_data_oe_n_out <= rd_byte_q[rd_idx];
		end
	end

	// ------------------------------------------------------------------------
	// Command execution
	// ------------------------------------------------------------------------
	wire [7:0] cmd_addr;
	wire [7:0] cmd_val;

	assign cmd_addr = shift_d[15:8];
	assign cmd_val  = shift_d[7:0];

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			input_sel_out    <= `RST_INPUT_SEL;
			loudness_out     <= `RST_LOUDNESS;
			bass_out         <= `RST_TONE;
			treble_out       <= `RST_TONE;
			volume_left_out  <= `RST_VOLUME;
			volume_right_out <= `RST_VOLUME;
			mode_out         <= `RST_MODE;
			cmd_done_out     <= 1'b0;
		end else begin
			cmd_done_out <= 1'b0;
			if (exec_d && cmd_addr[`ADDR_HI_MSB:`ADDR_HI_LSB] == `DEV_ADDR_HI) begin
				cmd_done_out <= 1'b1;
				case (cmd_addr[`FUNC_MSB:`FUNC_LSB])
					`FN_INPUT_SEL: begin
						input_sel_out <= cmd_val[`SEL_MSB:0];
					end
					`FN_LOUDNESS: begin
						loudness_out <= cmd_val[0];
					end
					`FN_BASS: begin
						bass_out <= cmd_val[`TONE_MSB:0];
					end
					`FN_TREBLE: begin
						treble_out <= cmd_val[`TONE_MSB:0];
					end
					`FN_VOL_LEFT: begin
						volume_left_out <= cmd_val[`VOL_MSB:0];
					end
					`FN_VOL_RIGHT: begin
						volume_right_out <= cmd_val[`VOL_MSB:0];
					end
					`FN_MODE: begin
						// Codes 0xx have no matrix setting and leave it as it was
						if (cmd_val[`MODE_VALID_BIT]) begin
							mode_out <= cmd_val[`MODE_MSB:0];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

endmodule // audio_control_serial_slave

// File: sim/audio_ctrl_asserts.sv
// Port checker for the control bus slave
`timescale 1ns/1ps

module audio_ctrl_check (
	input wire       sys_clk_in,                // Clock
	input wire       sys_rst_in,                // Reset
	input wire       bus_clk_in,                // Bus clock pin
	input wire       device_select_strobe_n_in, // Strobe pin
	input wire       bus_data_out,              // Drive value
	input wire       bus_data_oe_n_out,         // Drive enable
	input wire [1:0] input_sel_out,             // Input
	input wire       loudness_out,              // Loudness
	input wire [3:0] bass_out,                  // Bass
	input wire [3:0] treble_out,                // Treble
	input wire [5:0] volume_left_out,           // Left
	input wire [5:0] volume_right_out,          // Right
	input wire [2:0] mode_out,                  // Mode
	input wire       cmd_done_out               // Done
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire [25:0] set_w = {input_sel_out, loudness_out, bass_out, treble_out,
		volume_left_out, volume_right_out, mode_out};
	sequence pulse_s;
		cmd_done_out ##1 !cmd_done_out;
	endsequence
	reset_values_a: assert property (disable iff (1'b0) sys_rst_in |=>
		set_w == {2'h3, 1'h0, 4'h6, 4'h6, 6'h3f, 6'h3f, 3'h5}) else $error("bad reset value");
	update_on_done_a: assert property ($changed(set_w) |-> cmd_done_out)
		else $error("setting changed without command");
	done_pulse_a: assert property (cmd_done_out |-> pulse_s)
		else $error("done pulse too long");
	done_in_frame_a: assert property (cmd_done_out |->
		$past(device_select_strobe_n_in, 6) == 1'b0) else $error("done outside frame");
	volume_split_a: assert property ($changed(volume_left_out) |-> $stable(volume_right_out))
		else $error("volumes moved together");
	drive_low_a: assert property (bus_data_out == 1'b0) else $error("data driven high");
	release_idle_a: assert property (device_select_strobe_n_in [*6] |-> bus_data_oe_n_out)
		else $error("data driven while idle");
	drive_clk_low_a: assert property ($fell(bus_data_oe_n_out) |->
		$past(bus_clk_in, 3) == 1'b0) else $error("data changed with clock high");
	mode_legal_a: assert property (mode_out[2] == 1'b1) else $error("illegal mode taken");
endmodule // audio_ctrl_check

bind audio_control_serial_slave audio_ctrl_check i_chk (.sys_clk_in(sys_clk_in),
	.sys_rst_in(sys_rst_in), .bus_clk_in(bus_clk_in), .bus_data_out(bus_data_out),
	.device_select_strobe_n_in(device_select_strobe_n_in), .bus_data_oe_n_out(bus_data_oe_n_out),
	.input_sel_out(input_sel_out), .loudness_out(loudness_out), .bass_out(bass_out),
	.treble_out(treble_out), .volume_left_out(volume_left_out), .mode_out(mode_out),
	.volume_right_out(volume_right_out), .cmd_done_out(cmd_done_out));

// File: sim/bus_ctrl_model.sv
// Behavioural controller that frames commands on the three-wire control bus
`timescale 1ns/1ps

module bus_ctrl_model (
	input  wire sys_clk_in,   // Bench clock, paces the bus
	input  wire data_in,      // Resolved data line
	output reg  bus_clk_out,  // Bus clock, idle high
	output reg  strobe_n_out, // Select strobe
	output reg  data_oe_n_out // Low pulls the line low
);
	// Half a bus clock period in bench clocks; 4 gives the 320 ns bus clock
	int half_cycles = 4;
	initial begin
		bus_clk_out = 1'b1;
		strobe_n_out = 1'b1;
		data_oe_n_out = 1'b1;
	end
	task automatic half();
		repeat (half_cycles) @(negedge sys_clk_in);
	endtask
	// Short frames (n below 16) abort by raising the strobe early
	task automatic frame(input logic [15:0] w, input int n, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		strobe_n_out = 1'b0;
		half();
		for (i = 15; i > 15 - n; i--) begin
			bus_clk_out = 1'b0;
			// Line left to the pull-up during a read's value byte
			data_oe_n_out = ((i < 8) && (w[15:8] == 8'h47)) | w[i];
			half();
			bus_clk_out = 1'b1;
			half();
			// Sampled late in the high phase, after the slave's filter delay
			if (i < 8)
				rd[i] = data_in;
		end
		data_oe_n_out = 1'b1;
		strobe_n_out = 1'b1;
		repeat (3) half();
	endtask
endmodule // bus_ctrl_model

// File: sim/audio_control_serial_slave_tb.sv
// Self-checking bench for the control bus slave
`timescale 1ns/1ps

module audio_control_serial_slave_tb;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        st1_n = 1'b1;
	logic        st2_n = 1'b1;
	logic        bclk, strb_n, ctl_oe_n, dut_oe_n, dut_do, done, loud;
	logic [1:0]  sel;
	logic [3:0]  bass, treb;
	logic [5:0]  vl, vr;
	logic [2:0]  mode;
	logic [25:0] exp_s;
	logic [7:0]  rd;
	int          failures = 0;
	int          check_count = 0;
	int          dones = 0;
	int          cycles = 0;
	wire         data_w = ctl_oe_n & (dut_oe_n | dut_do);
	wire [25:0]  settings = {sel, loud, bass, treb, vl, vr, mode};
	logic [15:0] tbl [16] = '{16'h40fd, 16'h4002, 16'h4000, 16'h4003, 16'h41ff, 16'h42fc,
		16'h4203, 16'h4300, 16'h4309, 16'h4410, 16'h45ea, 16'h46fc, 16'h4606, 16'h4603,
		16'h4607, 16'h4605};

	audio_control_serial_slave i_dut (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
		.bus_clk_in(bclk), .device_select_strobe_n_in(strb_n), .bus_data_in(data_w),
		.bus_data_out(dut_do), .bus_data_oe_n_out(dut_oe_n), .status1_n_in(st1_n),
		.status2_n_in(st2_n), .input_sel_out(sel), .loudness_out(loud), .bass_out(bass),
		.treble_out(treb), .volume_left_out(vl), .volume_right_out(vr), .mode_out(mode),
		.cmd_done_out(done));
	bus_ctrl_model i_ctl (.sys_clk_in(sys_clk), .data_in(data_w), .bus_clk_out(bclk),
		.strobe_n_out(strb_n), .data_oe_n_out(ctl_oe_n));

	initial forever #20 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (done === 1'b1)
			dones++;
		if (cycles == 6000) begin
			failures++;
			results();
		end
	end

	task automatic check(input string name, input logic [25:0] seen, input logic [25:0] want);
		check_count++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One frame, then the settings and the done count against the expected state
	task automatic cmd(input logic [15:0] w, input int n);
		int   d0;
		logic ok;
		d0 = dones;
		ok = (n == 16) && (w[15:11] == 5'h08);
		i_ctl.frame(w, n, rd);
		if (ok) begin
			case (w[10:8])
				3'h0: exp_s[25:24] = w[1:0];
				3'h1: exp_s[23] = w[0];
				3'h2: exp_s[22:19] = w[3:0];
				3'h3: exp_s[18:15] = w[3:0];
				3'h4: exp_s[14:9] = w[5:0];
				3'h5: exp_s[8:3] = w[5:0];
				3'h6: if (w[2]) exp_s[2:0] = w[2:0];
				default: ;
			endcase
		end
		check("settings", settings, exp_s);
		check("done count", 26'(dones - d0), 26'(ok));
	endtask

	initial begin
		int i;
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		exp_s = {2'h3, 1'h0, 4'h6, 4'h6, 6'h3f, 6'h3f, 3'h5};
		check("reset", settings, exp_s);
		for (i = 0; i < 16; i++)
			cmd(tbl[i], 16);
		cmd(16'h4100, 16);
		cmd(16'h4810, 16);
		cmd(16'h4401, 9);
		// One frame with the bus clock slowed to just under 1 MHz
		i_ctl.half_cycles = 13;
		cmd(16'h4520, 16);
		i_ctl.half_cycles = 4;
		st1_n = 1'b0;
		cmd(16'h4700, 16);
		check("status", 26'(rd), 26'(8'hfe));
		st1_n = 1'b1;
		st2_n = 1'b0;
		cmd(16'h4700, 16);
		check("status", 26'(rd), 26'(8'hfd));
		// Reset in mid-run with the bus idle must bring back every default
		sys_rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		exp_s = {2'h3, 1'h0, 4'h6, 4'h6, 6'h3f, 6'h3f, 3'h5};
		check("reset again", settings, exp_s);
		cmd(16'h4410, 16);
		results();
	end
endmodule // audio_control_serial_slave_tb
